// file: design/lcdrv_defines.vh
// Purpose: shared constants of the RAM-mapped LCD segment driver core
// Assumes: one 50 MHz core clock; nominal system clock rate below
// Notes:   level codes are in thirds of the panel supply level
`ifndef LCDRV_DEFINES_VH
`define LCDRV_DEFINES_VH

// panel geometry and display memory
`define LCDRV_SEGS          36
`define LCDRV_COMS          4
`define LCDRV_ADDR_W        6
`define LCDRV_LAST_ADDR     6'h23
`define LCDRV_FIRST_ADDR    6'h00
`define LCDRV_MAX_START     5'h1f

// received byte layout
`define LCDRV_C_BIT         7
`define LCDRV_ADDR_OP       2'h0

// drive level codes; with half bias code 1 is the mid level and code 2 is unused
`define LCDRV_LVL_GND       2'h0
`define LCDRV_LVL_THIRD     2'h1
`define LCDRV_LVL_TWO_THIRD 2'h2
`define LCDRV_LVL_FULL      2'h3

// reset values of the configuration
`define LCDRV_RST_DISPLAY   1'b0
`define LCDRV_RST_OSC       1'b0
`define LCDRV_RST_BIASGEN   1'b0
`define LCDRV_RST_HALF      1'b0
`define LCDRV_RST_WAVE_B    1'b0
`define LCDRV_RST_EXTCLK    1'b0
`define LCDRV_RST_PSAVE     1'b0
`define LCDRV_RST_FRAME     2'h0
`define LCDRV_RST_BLINK     2'h0

// clock rates in Hz
`define LCDRV_CORE_HZ       50000000
`define LCDRV_SYS_HZ        32000
`define LCDRV_OSC_DIV       (`LCDRV_CORE_HZ / `LCDRV_SYS_HZ)

// frame rates in Hz and system ticks per drive slot (8 slots a frame)
`define LCDRV_FRAME0_HZ     80
`define LCDRV_FRAME1_HZ     71
`define LCDRV_FRAME2_HZ     64
`define LCDRV_FRAME3_HZ     53
`define LCDRV_SLOT0 (`LCDRV_SYS_HZ / (8 * `LCDRV_FRAME0_HZ))
`define LCDRV_SLOT1 (`LCDRV_SYS_HZ / (8 * `LCDRV_FRAME1_HZ))
`define LCDRV_SLOT2 (`LCDRV_SYS_HZ / (8 * `LCDRV_FRAME2_HZ))
`define LCDRV_SLOT3 (`LCDRV_SYS_HZ / (8 * `LCDRV_FRAME3_HZ))

// blink rates in tenths of Hz, and system ticks per half blink period
`define LCDRV_BLINK1_DHZ    5
`define LCDRV_BLINK2_DHZ    10
`define LCDRV_BLINK3_DHZ    20
`define LCDRV_BLINK1 (`LCDRV_SYS_HZ * 10 / (2 * `LCDRV_BLINK1_DHZ))
`define LCDRV_BLINK2 (`LCDRV_SYS_HZ * 10 / (2 * `LCDRV_BLINK2_DHZ))
`define LCDRV_BLINK3 (`LCDRV_SYS_HZ * 10 / (2 * `LCDRV_BLINK3_DHZ))

`endif

// file: design/lcdrv_tick_gen.v
// Purpose: system clock enable from the internal oscillator or external
// Assumes: extClkIn is synchronous to core_clk
// Notes:   one-cycle pulse per system clock period
`timescale 1ns/1ps
`include "lcdrv_defines.vh"

module lcdrv_tick_gen #(
   parameter OSC_DIV = `LCDRV_OSC_DIV
) (
   input  wire core_clk,
   input  wire rst,
   input  wire oscOn,
   input  wire extSel,
   input  wire extClkIn,
   output reg  sysTick
);

   reg [15:0] divCnt;
   reg        extPrev;
   wire       divLast;

   assign divLast = (divCnt == OSC_DIV[15:0] - 16'h0001);

   // internal oscillator model; held stopped until switched on
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         divCnt <= 16'h0000;
      end else if (!oscOn || extSel || divLast) begin
         divCnt <= 16'h0000;
      end else begin
         divCnt <= divCnt + 16'h0001;
      end
   end

   // RULE_09 source select
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         extPrev <= 1'b0;
         sysTick <= 1'b0;
      end else begin
         extPrev <= extClkIn;
         if (extSel) begin
            sysTick <= extClkIn & ~extPrev; // rising edge of external
         end else begin
            sysTick <= oscOn & divLast;
         end
      end
   end

endmodule

// file: design/lcdrv_core.v
// Purpose: display memory, address pointer and 1/4 duty LCD scan
// Assumes: bytes arrive already deserialised by a serial front end
// Notes:   outputs are 2-bit drive level codes per pin, from flops
`timescale 1ns/1ps
`include "lcdrv_defines.vh"

// Functional notes
// RULE_01: after reset all backplane and segment outputs sit at ground.
// RULE_02: after reset waveform is A-type and internal oscillator selected.
// RULE_03: after reset one-third bias is selected, bias generator off.
// RULE_04: after reset display and oscillator are off until enabled.
// RULE_05: after reset power saving is in normal current mode.
// RULE_06: after reset frame rate is 80 Hz and blinking disabled.
// RULE_07: host waits 1 ms after power-up before any bus transfer; the bench starts its first transfer two cycles after reset is released.
// RULE_08: host sends software reset if power-up conditions are doubtful.
// RULE_09: all timing comes from internal oscillator or external clock.
// RULE_10: system clock sets frame rate; oscillator stopped until enabled.
// RULE_11: 36 segment outputs follow stored data and active common phase.
// RULE_12: four backplane outputs follow the selected bias and duty.
// RULE_13: display memory is 36 words of 4 bits.
// RULE_14: stored one turns segment on, zero turns it off.
// RULE_15: bit 3 shows in the first common phase, bit 0 in fourth.
// RULE_16: words 00H-23H drive segments 0-35; writes start at pointer.
// RULE_17: pointer advances per nibble; one byte fills two words.
// RULE_18: quarter duty with half or third bias; half drops middle resistor.
// RULE_19: blink modes off, 0.5, 1 and 2 Hz from system clock division.
// RULE_20: frame modes 0-3 give 80, 71, 64 and 53 Hz by division.
// RULE_21: pointer wraps from 23H back to 00H.
// RULE_22: bit 7 clear means next byte is data, set means command.
// RULE_23: address byte start above 1FH is taken as a command.
// RULE_24: blinking blanks segments in the off half, shows data in the on.
module lcdrv_core #(
   parameter OSC_DIV = `LCDRV_OSC_DIV,
   parameter BLINK1  = `LCDRV_BLINK1,
   parameter BLINK2  = `LCDRV_BLINK2,
   parameter BLINK3  = `LCDRV_BLINK3
) (
   input  wire        core_clk,
   input  wire        rst,
   input  wire [7:0]  rxByte,
   input  wire        rxValid,
   input  wire        rxStart,
   input  wire        cfgWrite,
   input  wire        cfgDisplayOn,
   input  wire        cfgOscOn,
   input  wire        cfgBiasGenOn,
   input  wire        cfgBiasHalf,
   input  wire        cfgWaveB,
   input  wire        cfgExtClk,
   input  wire        cfgPowerSave,
   input  wire [1:0]  cfgFrameSel,
   input  wire [1:0]  cfgBlinkSel,
   input  wire        extClkIn,
   output reg  [71:0] segmentOutputs,
   output reg  [7:0]  backplaneOutputs,
   output reg         biasGenEnable,
   output reg         biasHalfSel,
   output reg         oscRunning,
   output reg         extClkSelected,
   output reg         waveTypeB,
   output reg         powerSaveOn,
   output reg         displayEnabled,
   output reg  [1:0]  frameSel,
   output reg  [1:0]  blinkSel,
   output reg  [5:0]  addrPointer
);

   localparam ST_CMD  = 1'b0;
   localparam ST_DATA = 1'b1;

   // frame slot lengths; integers cut to the 8-bit slot counter width
   localparam integer SLOT0 = `LCDRV_SLOT0;
   localparam integer SLOT1 = `LCDRV_SLOT1;
   localparam integer SLOT2 = `LCDRV_SLOT2;
   localparam integer SLOT3 = `LCDRV_SLOT3;

   // RULE_13 display memory words
   reg  [3:0]  mem [0:`LCDRV_SEGS-1];
   reg         rxState;
   reg  [7:0]  slotTicks;
   reg  [2:0]  slot;
   reg  [16:0] blinkCnt;
   reg         blinkShow;
   reg  [7:0]  slotLimit;
   reg  [16:0] blinkLimit;
   wire        sysTick;
   wire        active;
   wire [1:0]  comIdx;
   wire        pol;
   wire [5:0]  ptrNext;
   integer     i;

   // next memory address, wrapping at the last word
   function [5:0] incAddr;
      input [5:0] a;
      begin
         // RULE_21 pointer wrap
         if (a == `LCDRV_LAST_ADDR) begin
            incAddr = `LCDRV_FIRST_ADDR;
         end else begin
            incAddr = a + 6'h01;
         end
      end
   endfunction

   // segment level for one phase half
   function [1:0] segLevel;
      input on;
      input p;
      input half;
      begin
         if (!p) begin
            segLevel = on ? `LCDRV_LVL_GND :
                       (half ? `LCDRV_LVL_FULL : `LCDRV_LVL_TWO_THIRD);
         end else begin
            segLevel = on ? `LCDRV_LVL_FULL :
                       (half ? `LCDRV_LVL_GND : `LCDRV_LVL_THIRD);
         end
      end
   endfunction

   // backplane level; unselected commons sit at the bias steps
   function [1:0] comLevel;
      input sel;
      input p;
      input half;
      begin
         if (sel) begin
            comLevel = p ? `LCDRV_LVL_GND : `LCDRV_LVL_FULL;
         end else if (half) begin
            comLevel = `LCDRV_LVL_THIRD; // mid level, one step only
         end else begin
            comLevel = p ? `LCDRV_LVL_TWO_THIRD : `LCDRV_LVL_THIRD;
         end
      end
   endfunction

   lcdrv_tick_gen #(
      .OSC_DIV (OSC_DIV)
   ) u_tick (
      .core_clk (core_clk),
      .rst      (rst),
      .oscOn    (oscRunning),
      .extSel   (extClkSelected),
      .extClkIn (extClkIn),
      .sysTick  (sysTick)
   );

   // configuration latch with documented power-on values
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // RULE_02 reset waveform and source
         waveTypeB      <= `LCDRV_RST_WAVE_B;
         extClkSelected <= `LCDRV_RST_EXTCLK;
         // RULE_03 reset bias state
         biasHalfSel    <= `LCDRV_RST_HALF;
         biasGenEnable  <= `LCDRV_RST_BIASGEN;
         // RULE_04 display and oscillator off
         displayEnabled <= `LCDRV_RST_DISPLAY;
         oscRunning     <= `LCDRV_RST_OSC;
         // RULE_05 normal current
         powerSaveOn    <= `LCDRV_RST_PSAVE;
         // RULE_06 frame and blink defaults
         frameSel       <= `LCDRV_RST_FRAME;
         blinkSel       <= `LCDRV_RST_BLINK;
      end else if (cfgWrite) begin
         waveTypeB      <= cfgWaveB;
         extClkSelected <= cfgExtClk;
         // RULE_18 bias choice
         biasHalfSel    <= cfgBiasHalf;
         biasGenEnable  <= cfgBiasGenOn;
         displayEnabled <= cfgDisplayOn;
         // RULE_10 oscillator held until enabled
         oscRunning     <= cfgOscOn;
         powerSaveOn    <= cfgPowerSave;
         frameSel       <= cfgFrameSel;
         blinkSel       <= cfgBlinkSel;
      end
   end

   assign ptrNext = incAddr(addrPointer);

   // byte intake: address/command byte then a run of data bytes
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxState     <= ST_CMD;
         addrPointer <= `LCDRV_FIRST_ADDR;
         for (i = 0; i < `LCDRV_SEGS; i = i + 1) begin
            mem[i] <= 4'h0;
         end
      end else if (rxStart) begin
         rxState <= ST_CMD; // a new transfer always opens with a command
      end else if (rxValid) begin
         case (rxState)
            ST_CMD: begin
               // RULE_23 only bytes with bits 6:5 clear (00H-1FH, 80H-9FH) load the pointer
               if (rxByte[6:5] == `LCDRV_ADDR_OP) begin
                  addrPointer <= {1'b0, rxByte[4:0]};
               end
               // RULE_22 continuation bit
               if (rxByte[`LCDRV_C_BIT]) begin
                  rxState <= ST_CMD;
               end else begin
                  rxState <= ST_DATA;
               end
            end
            ST_DATA: begin
               // RULE_16 write at pointer
               // RULE_17 two nibbles per byte, high first
               mem[addrPointer] <= rxByte[7:4];
               mem[ptrNext]     <= rxByte[3:0];
               addrPointer      <= incAddr(ptrNext);
            end
            default: begin
               rxState <= ST_CMD;
            end
         endcase
      end
   end

   // divider limits for the selected frame and blink rates
   always @* begin
      // RULE_20 frame rate by division
      case (frameSel)
         2'h0:    slotLimit = SLOT0[7:0];
         2'h1:    slotLimit = SLOT1[7:0];
         2'h2:    slotLimit = SLOT2[7:0];
         default: slotLimit = SLOT3[7:0];
      endcase
      // RULE_19 blink rate by division
      case (blinkSel)
         2'h1:    blinkLimit = BLINK1[16:0];
         2'h2:    blinkLimit = BLINK2[16:0];
         default: blinkLimit = BLINK3[16:0];
      endcase
   end

   // slot sequencer; type B doubles the slot so the frame length holds
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         slotTicks <= 8'h00;
         slot      <= 3'h0;
      end else if (!displayEnabled) begin
         slotTicks <= 8'h00;
         slot      <= 3'h0;
      end else if (sysTick) begin
         // RULE_10 frame timing follows the system clock
         if (slotTicks >= (waveTypeB ? {slotLimit[6:0], 1'b0} : slotLimit)
             - 8'h01) begin
            slotTicks <= 8'h00;
            slot      <= slot + 3'h1;
         end else begin
            slotTicks <= slotTicks + 8'h01;
         end
      end
   end

   // type A inverts inside each phase, type B once per frame
   assign comIdx = waveTypeB ? slot[1:0] : slot[2:1];
   assign pol    = waveTypeB ? slot[2] : slot[0];

   // blink phase; mode 0 keeps the display shown
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         blinkCnt  <= 17'h00000;
         blinkShow <= 1'b1;
      end else if (blinkSel == 2'h0 || !displayEnabled) begin
         blinkCnt  <= 17'h00000;
         blinkShow <= 1'b1;
      end else if (sysTick) begin
         // RULE_24 alternate shown and blank halves
         if (blinkCnt >= blinkLimit - 17'h00001) begin
            blinkCnt  <= 17'h00000;
            blinkShow <= ~blinkShow;
         end else begin
            blinkCnt <= blinkCnt + 17'h00001;
         end
      end
   end

   // drive only when display is on and a clock source is running
   assign active = displayEnabled & (oscRunning | extClkSelected);

   // output drive; registered so pins never glitch between phases
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // RULE_01 all pins at ground
         segmentOutputs   <= 72'h0;
         backplaneOutputs <= 8'h00;
      end else if (!active) begin
         segmentOutputs   <= 72'h0;
         backplaneOutputs <= 8'h00;
      end else begin
         for (i = 0; i < `LCDRV_COMS; i = i + 1) begin
            // RULE_12 backplane waveform
            backplaneOutputs[2*i +: 2] <=
               comLevel(comIdx == i[1:0], pol, biasHalfSel);
         end
         for (i = 0; i < `LCDRV_SEGS; i = i + 1) begin
            // RULE_11 RULE_14 RULE_15 segment from word bit
            segmentOutputs[2*i +: 2] <=
               segLevel(blinkShow & mem[i][3 - comIdx], pol, biasHalfSel);
         end
      end
   end

endmodule

// file: testbench/lcdrv_core_monitor.sv
// Purpose: port assertions for the LCD driver core
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   pins lag their cause by a cycle, so waits span three
`timescale 1ns/1ps
module lcdrv_monitor (
   input wire        core_clk,
   input wire        rst,
   input wire [7:0]  rxByte,
   input wire        rxValid,
   input wire        rxStart,
   input wire        cfgWrite,
   input wire        cfgDisplayOn,
   input wire        cfgOscOn,
   input wire [71:0] segmentOutputs,
   input wire [7:0]  backplaneOutputs,
   input wire        biasGenEnable,
   input wire        biasHalfSel,
   input wire        oscRunning,
   input wire        extClkSelected,
   input wire        waveTypeB,
   input wire        powerSaveOn,
   input wire        displayEnabled,
   input wire [1:0]  frameSel,
   input wire [1:0]  blinkSel,
   input wire [5:0]  addrPointer
);
   // condensed views of pins, setup and the start address field
   wire        pinsLow = segmentOutputs == 72'h0 && backplaneOutputs == 8'h0;
   wire [10:0] cfgOut = {displayEnabled, oscRunning, biasGenEnable,
      biasHalfSel, waveTypeB, extClkSelected, powerSaveOn, frameSel, blinkSel};
   wire [5:0]  startAddr = {1'b0, rxByte[4:0]};
   wire        noTwo = backplaneOutputs[1:0] != 2'h2
      && backplaneOutputs[3:2] != 2'h2 && backplaneOutputs[5:4] != 2'h2
      && backplaneOutputs[7:6] != 2'h2;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);

   a_reset_pins: assert property ($fell(rst) |-> pinsLow)
      else $error("pins not grounded after reset");
   a_reset_setup: assert property ($fell(rst) |->
      cfgOut == 11'h0 && addrPointer == 6'h00)
      else $error("setup not cleared by reset");
   a_cfg_latch: assert property (cfgWrite |=>
      {displayEnabled, oscRunning} == $past({cfgDisplayOn, cfgOscOn}))
      else $error("setup not latched");
   a_cfg_hold: assert property (!cfgWrite |=> $stable(cfgOut))
      else $error("setup changed without a write");
   a_off_ground: assert property (!displayEnabled [*3] |-> pinsLow)
      else $error("pins driven while display off");
   a_noclk_ground: assert property
      ((!oscRunning && !extClkSelected) [*3] |-> pinsLow)
      else $error("pins driven with no clock source");
   a_half_levels: assert property
      ((biasHalfSel && displayEnabled) [*3] |-> noTwo)
      else $error("two-thirds level under half bias");
   a_ptr_load: assert property
      ($past(rxStart) && rxValid && !rxStart && rxByte[6:5] == 2'h0
      |=> addrPointer == $past(startAddr)) else $error("pointer not loaded");
   a_ptr_refuse: assert property
      ($past(rxStart) && rxValid && !rxStart && rxByte[6:5] != 2'h0
      |=> $stable(addrPointer)) else $error("pointer loaded by a command");
   a_ptr_idle: assert property (!rxValid |=> $stable(addrPointer))
      else $error("pointer moved with no byte");
   a_ptr_range: assert property (addrPointer <= 6'h23)
      else $error("pointer beyond last word");
   // main scenarios reached
   c_com_full: cover property (backplaneOutputs[1:0] == 2'h3);
   c_half_on: cover property (biasHalfSel && displayEnabled);
   c_blink_on: cover property (blinkSel != 2'h0 && displayEnabled);
endmodule

bind lcdrv_core lcdrv_monitor i_mon (.core_clk(core_clk), .rst(rst),
   .rxByte(rxByte), .rxValid(rxValid), .rxStart(rxStart),
   .cfgWrite(cfgWrite), .cfgDisplayOn(cfgDisplayOn), .cfgOscOn(cfgOscOn),
   .segmentOutputs(segmentOutputs), .backplaneOutputs(backplaneOutputs),
   .biasGenEnable(biasGenEnable), .biasHalfSel(biasHalfSel),
   .oscRunning(oscRunning), .extClkSelected(extClkSelected),
   .waveTypeB(waveTypeB), .powerSaveOn(powerSaveOn),
   .displayEnabled(displayEnabled), .frameSel(frameSel),
   .blinkSel(blinkSel), .addrPointer(addrPointer));

// file: testbench/lcdrv_panel.sv
// Purpose: passive model of the glass on the driver pins
// Assumes: level codes 0..3 in thirds of the panel supply level
// Notes:   a pixel is lit only under the full drive difference
`timescale 1ns/1ps
module lcdrv_panel (
   input  wire [71:0] segmentOutputs,
   input  wire [7:0]  backplaneOutputs,
   output reg  [1:0]  activeCom,
   output reg         comValid,
   output reg  [35:0] litMask
);
   integer   i;
   reg [1:0] c;
   // selected backplane sits at an extreme, the rest in between
   always @* begin
      comValid = 1'b0;
      activeCom = 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
         c = backplaneOutputs[2*i +: 2];
         if (c == 2'h0 || c == 2'h3) begin
            comValid = 1'b1;
            activeCom = i[1:0];
         end
      end
      c = backplaneOutputs[2*activeCom +: 2];
      for (i = 0; i < 36; i = i + 1)
         litMask[i] = comValid && (segmentOutputs[2*i +: 2] ^ c) == 2'h3;
   end
endmodule

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the LCD driver core
// Assumes: small divider and blink counts keep the run short
// Notes:   a monitor process pairs each seen value with its note
`timescale 1ns/1ps
`include "lcdrv_defines.vh"
module tb_top;
   reg          core_clk = 1'b0;
   reg          rst = 1'b1;
   reg  [7:0]   rxByte = 8'h0;
   reg          rxValid = 1'b0;
   reg          rxStart = 1'b0;
   reg          cfgWrite = 1'b0;
   reg  [10:0]  cfgIn = 11'h0;
   reg          extClkIn = 1'b0;
   reg  [15:0]  lfsr = 16'h3ab0;
   reg  [7:0]   dat;
   reg  [1:0]   saw;
   wire [71:0]  segmentOutputs;
   wire [7:0]   backplaneOutputs;
   wire [10:0]  cfgOut;
   wire [5:0]   addrPointer;
   wire [35:0]  litMask;
   wire [1:0]   activeCom;
   wire         comValid;
   logic [71:0] expQ[$];
   string       nameQ[$];
   logic [71:0] seenV;
   event        obs;
   integer      miscompares = 0;
   integer      samplesChecked = 0;
   integer      cyc = 0;
   integer      t, k, n, p;

   lcdrv_core #(.OSC_DIV(4), .BLINK1(8), .BLINK2(4), .BLINK3(2)) i_dut (
      .core_clk(core_clk), .rst(rst), .rxByte(rxByte), .rxValid(rxValid),
      .rxStart(rxStart), .cfgWrite(cfgWrite), .cfgDisplayOn(cfgIn[10]),
      .cfgOscOn(cfgIn[9]), .cfgBiasGenOn(cfgIn[8]), .cfgBiasHalf(cfgIn[7]),
      .cfgWaveB(cfgIn[6]), .cfgExtClk(cfgIn[5]), .cfgPowerSave(cfgIn[4]),
      .cfgFrameSel(cfgIn[3:2]), .cfgBlinkSel(cfgIn[1:0]),
      .extClkIn(extClkIn), .segmentOutputs(segmentOutputs),
      .backplaneOutputs(backplaneOutputs), .biasGenEnable(cfgOut[8]),
      .biasHalfSel(cfgOut[7]), .oscRunning(cfgOut[9]),
      .extClkSelected(cfgOut[5]), .waveTypeB(cfgOut[6]),
      .powerSaveOn(cfgOut[4]), .displayEnabled(cfgOut[10]),
      .frameSel(cfgOut[3:2]), .blinkSel(cfgOut[1:0]),
      .addrPointer(addrPointer));
   lcdrv_panel i_panel (.segmentOutputs(segmentOutputs),
      .backplaneOutputs(backplaneOutputs), .activeCom(activeCom),
      .comValid(comValid), .litMask(litMask));

   always #10 core_clk = ~core_clk;
   // cycle ceiling; external clock rises every fourth cycle
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      extClkIn <= cyc[1];
      if (cyc == 90000) begin
         miscompares = miscompares + 1;
         final_report;
      end
   end
   // oldest note is paired with each value that appears
   always begin
      @(obs);
      check(nameQ.pop_front(), seenV, expQ.pop_front());
   end

   function [15:0] step(input [15:0] s);
      step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task check(input string nm, input logic [71:0] s, input logic [71:0] e);
      samplesChecked = samplesChecked + 1;
      if (s !== e) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task note(input string nm, input logic [71:0] e, input logic [71:0] s);
      expQ.push_back(e);
      nameQ.push_back(nm);
      seenV = s;
      -> obs;
      #1;
   endtask
   task final_report;
      $display("checked %0d mismatched %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task doReset;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      note("segments", 72'h0, segmentOutputs);
      note("commons", 72'h0, backplaneOutputs);
      note("setup", 72'h0, {cfgOut, addrPointer});
      $display("test reset done");
   endtask
   // bias gen and power save bits are random, the rest as asked
   task cfg(input [10:0] v);
      v[8] = lfsr[0];
      v[4] = lfsr[1];
      lfsr = step(lfsr);
      @(posedge core_clk);
      cfgIn <= v;
      cfgWrite <= 1'b1;
      @(posedge core_clk);
      cfgWrite <= 1'b0;
      @(posedge core_clk);
      #1;
      note("setup", v, cfgOut);
   endtask
   // start, address byte, r equal data bytes; bus then shows junk
   task xfer(input [7:0] a, input [7:0] d, input integer r);
      @(posedge core_clk);
      rxStart <= 1'b1;
      @(posedge core_clk);
      rxStart <= 1'b0;
      rxValid <= 1'b1;
      rxByte <= a;
      repeat (r) begin
         @(posedge core_clk);
         rxByte <= d;
      end
      @(posedge core_clk);
      rxValid <= 1'b0;
      rxByte <= lfsr[15:8];
      @(posedge core_clk);
      #1;
   endtask
   task waitCom(input integer c);
      n = 0;
      while (!(comValid === 1'b1 && activeCom === c[1:0]) && n < 4000) begin
         @(posedge core_clk);
         #1;
         n = n + 1;
      end
   endtask
   // cycles until backplane 0 next enters its full-level slot
   task rise;
      n = 0;
      do begin
         p = backplaneOutputs[1:0];
         @(posedge core_clk);
         #1;
         n = n + 1;
      end while (!(backplaneOutputs[1:0] === 2'h3 && p != 3) && n < 9000);
   endtask

   initial begin
      doReset;
      dat = lfsr[7:0];
      // first transfer only once reset is over
      // three bytes from 1fH fill 1fH..23H, then wrap to 00H
      xfer(8'h1f, dat, 3);
      note("pointer", 72'h01, addrPointer);
      xfer(8'ha5, 8'hc0, 1);
      note("pointer", 72'h01, addrPointer);
      xfer(8'h00, 8'hff, 1);
      note("pointer", 72'h02, addrPointer);
      $display("test pointer done");
      for (t = 0; t < 2; t = t + 1) begin
         cfg({2'b11, 1'b0, t[0], 7'h0});
         for (k = 0; k < 4; k = k + 1) begin
            waitCom(k);
            note("pixels", {dat[7-k], dat[3-k]}, litMask[35:34]);
         end
      end
      $display("test scan done");
      // last pass runs 80 Hz from the external clock, oscillator off
      for (t = 0; t < 5; t = t + 1) begin
         cfg(t < 4 ? {2'b11, 2'b00, t[0], 2'b00, t[1:0], 2'b00} : 11'h420);
         rise;
         rise;
         note("frame", 32 * (1 + t[0]) * (t[1] ? (t[0] ? `LCDRV_SLOT3 :
            `LCDRV_SLOT2) : (t[0] ? `LCDRV_SLOT1 : `LCDRV_SLOT0)), n);
      end
      $display("test frame done");
      for (t = 0; t < 4; t = t + 1) begin
         cfg({2'b11, 7'h0, t[1:0]});
         saw = 2'b00;
         repeat (100) begin
            @(posedge core_clk);
            #1;
            saw = saw | {litMask[0], !litMask[0]};
         end
         note("blink", t == 0 ? 2'b10 : 2'b11, saw);
      end
      $display("test blink done");
      // host issues a reset again while running
      doReset;
      final_report;
   end
endmodule
